// ### irf_pkg.sv
// Purpose: constants shared by the infrared frame status and config registers
// Assumes: byte address of a register is four times its index
// Notes: indices are per register set
package irf_pkg;
	localparam logic [2:0] IDX_CFG2 = 3'h0;
	localparam logic [2:0] IDX_FLOW = 3'h2;
	localparam logic [2:0] IDX_SSR = 3'h3;
	localparam logic [2:0] IDX_CFG1 = 3'h4;
	localparam logic [2:0] IDX_FSH = 3'h5;
	localparam logic [2:0] IDX_LENLO = 3'h6;
	localparam logic [2:0] IDX_LENHI = 3'h7;
	localparam logic [7:0] SET5_CODE = 8'hec;
	localparam logic [7:0] SET6_CODE = 8'hf0;
	localparam logic [7:0] RST_FLOW = 8'h00;
	localparam logic [7:0] RST_CFG1 = 8'h00;
	localparam logic [7:0] RST_CFG2 = 8'h20;
	localparam logic [7:0] HSR_MASKED = 8'h30;
	localparam logic [7:0] CFG1_MASK = 8'h73;
	localparam logic [7:0] CFG2_MASK = 8'hf6;
	localparam logic [7:0] FLOW_MASK = 8'hef;
	localparam int C1_LEVEL = 6;
	localparam int C1_SPLIT = 5;
	localparam int C1_ALTRX = 4;
	localparam int C1_HSMASK = 1;
	localparam int C1_DUPLEX = 0;
	localparam int C2_MODBYP = 7;
	localparam int C2_DEMBYP = 6;
	localparam int C2_FASTW = 5;
	localparam int C2_MIDW = 4;
	localparam int C2_INV = 2;
	localparam int C2_OMIT = 1;
	localparam logic [3:0] LEVEL_LOW = 4'h2;
	localparam logic [3:0] LEVEL_HIGH = 4'h4;
	localparam int CLK_HZ = 200000000;
	localparam int ASK_HZ = 500000;
	localparam int ASK_HALF = CLK_HZ / (2 * ASK_HZ);
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [12:0] LEN_ZERO = 13'h0000;
endpackage : irf_pkg

// ### irf_regs.sv
// Purpose: infrared config, flow control and frame status queue registers on AHB-Lite
// Assumes: receiver and transmitter byte strobes are synchronous to clk
// Notes: zero wait states; read data registered at the address phase
// Function
// - flow settings act only with flow_ctl_on set
// - selector write switches set; read gives ec in set 5, f0 in set 6
// - threshold 2 or 4 entries raises queue irq
// - auto split cuts tx into equal frames
// - alternate pin feeds infrared receive data
// - masked handshake status reads 30 hex
// - duplex select half or full
// - entry valid reflects queue bottom occupancy
// - frames dropped set on any lost frame
// - length overrun flag per status entry
// - line layer fault flag per entry
// - check fail flag per entry
// - receive queue overflow sticky flag
// - status queue overflow sticky flag
// - 13-bit length; high read pops entry
// - dropped mode: low gives count, high zero
// - ask modulation and demodulation at 500 kHz
// - crc width selects, fast width resets one
// - check invert drives inverted crc output
// - check omit suppresses crc append
// - long tx stream split at tx_frame_len
// - rx overrun discards until next start flag
`timescale 1ns/1ps
module irf_regs
	import irf_pkg::*;
#(
	parameter int SQ_DEPTH = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [7:0] uartHandshake,
	input wire logic serialInPin,
	input wire logic irReceivePin,
	input wire logic txSerial,
	input wire logic rxByteValid,
	input wire logic rxStartFlag,
	input wire logic rxQueueFull,
	input wire logic frameDone,
	input wire logic framePhyErr,
	input wire logic frameCrcErr,
	input wire logic [12:0] rxMaxLen,
	input wire logic txByteValid,
	input wire logic [12:0] txFrameLen,
	output logic serialOutPin,
	output logic irRxData,
	output logic rxQueueWrite,
	output logic txFrameEnd,
	output logic statusQueueIrq,
	output logic [7:0] handshakeStatus,
	output logic [7:0] flowSettings,
	output logic duplexFull,
	output logic fastCheckWidth,
	output logic midCheckWidth,
	output logic checkInvert,
	output logic checkOmit
);
	localparam int PW = $clog2(SQ_DEPTH);
	localparam int CW = $clog2(ASK_HALF * 2 + 1);

	logic [7:0] set_r;
	logic [7:0] flow_r;
	logic [7:0] cfg1_r;
	logic [7:0] cfg2_r;
	logic wrPend_r;
	logic [2:0] wrIdx_r;
	logic [31:0] rd_nxt;
	logic addrOk;
	logic rdAcc;
	logic wrAcc;
	logic [2:0] idx;
	logic inSet5;
	logic inSet6;
	logic [15:0] sq_mem [SQ_DEPTH];
	logic [PW:0] sqCnt_r;
	logic [PW-1:0] sqHead_r;
	logic [PW-1:0] sqTail_r;
	logic sqValid;
	logic sqFull;
	logic pop;
	logic push;
	logic [15:0] head;
	logic dropped_r;
	logic [7:0] dropCnt_r;
	logic rxOvf_r;
	logic sqOvf_r;
	logic fshRead;
	logic lenHiRead;
	logic [12:0] rxCnt_r;
	logic discard_r;
	logic overSeen_r;
	logic rxOverStep;
	logic [12:0] txCnt_r;
	logic [CW-1:0] carCnt_r;
	logic carrier_r;
	logic [CW-1:0] edgeAge_r;
	logic inPrev_r;
	logic rawRx;

	assign idx = haddr[4:2];
	assign addrOk = (haddr[31:5] == 27'h0000000) && (haddr[1:0] == 2'h0);
	assign rdAcc = hsel && hready && htrans[1] && !hwrite && addrOk;
	assign wrAcc = hsel && hready && htrans[1] && hwrite && addrOk;
	assign inSet5 = (set_r == SET5_CODE);
	assign inSet6 = (set_r == SET6_CODE);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// bus write: address phase latched, data taken next cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wrPend_r <= 1'b0;
			wrIdx_r <= 3'h0;
		end else begin
			if (hready) begin
				wrPend_r <= wrAcc;
				wrIdx_r <= idx;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			set_r <= SET5_CODE;
			flow_r <= RST_FLOW;
			cfg1_r <= RST_CFG1;
			cfg2_r <= RST_CFG2;
		end else if (wrPend_r) begin
			if (wrIdx_r == IDX_SSR) begin
				set_r <= hwdata[7:0];
			end
			if (inSet5 && wrIdx_r == IDX_FLOW) begin
				flow_r <= hwdata[7:0] & FLOW_MASK;
			end
			if (inSet5 && wrIdx_r == IDX_CFG1) begin
				cfg1_r <= hwdata[7:0] & CFG1_MASK;
			end
			if (inSet6 && wrIdx_r == IDX_CFG2) begin
				cfg2_r <= hwdata[7:0] & CFG2_MASK;
			end
		end
	end

	assign head = sq_mem[sqHead_r];
	assign sqValid = (sqCnt_r != '0);
	assign sqFull = (sqCnt_r == (PW+1)'(SQ_DEPTH));
	assign fshRead = rdAcc && inSet5 && (idx == IDX_FSH);
	assign lenHiRead = rdAcc && inSet5 && (idx == IDX_LENHI);
	assign pop = lenHiRead && sqValid;
	assign push = frameDone && (!sqFull || pop);

	always_comb begin
		rd_nxt = 32'h00000000;
		if (idx == IDX_SSR && (inSet5 || inSet6)) begin
			rd_nxt[7:0] = set_r;
		end else if (inSet5) begin
			unique case (idx)
				IDX_FLOW: rd_nxt[7:0] = flow_r;
				IDX_CFG1: rd_nxt[7:0] = cfg1_r;
				// per-entry flags come from the bottom entry; dropped and overflow flags are sticky
				IDX_FSH: rd_nxt[7:0] = {sqValid, dropped_r, 1'b0,
					sqValid ? head[15:13] : 3'h0, rxOvf_r, sqOvf_r};
				// empty queue reads zero rather than an unwritten entry
				IDX_LENLO: rd_nxt[7:0] = dropped_r ? dropCnt_r :
					(sqValid ? head[7:0] : 8'h00);
				IDX_LENHI: rd_nxt[7:0] = (dropped_r || !sqValid) ? 8'h00 :
					{3'h0, head[12:8]};
				default: rd_nxt = 32'h00000000;
			endcase
		end else if (inSet6 && idx == IDX_CFG2) begin
			rd_nxt[7:0] = cfg2_r;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hrdata <= 32'h00000000;
		end else if (rdAcc) begin
			hrdata <= rd_nxt;
		end
	end

	// frame status queue: length in low bits, flags above
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sqCnt_r <= '0;
			sqHead_r <= '0;
			sqTail_r <= '0;
		end else begin
			if (push) begin
				sqTail_r <= PW'(sqTail_r + 1'b1);
			end
			if (pop) begin
				sqHead_r <= PW'(sqHead_r + 1'b1);
			end
			if (push && !pop) begin
				sqCnt_r <= (PW+1)'(sqCnt_r + 1'b1);
			end else if (pop && !push) begin
				sqCnt_r <= (PW+1)'(sqCnt_r - 1'b1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			sq_mem[sqTail_r] <= {overSeen_r || rxOverStep, framePhyErr, frameCrcErr,
				rxCnt_r};
		end
	end

	// sticky flags: set wins over clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dropped_r <= 1'b0;
			dropCnt_r <= 8'h00;
			rxOvf_r <= 1'b0;
			sqOvf_r <= 1'b0;
		end else begin
			if (frameDone && !push) begin
				dropped_r <= 1'b1;
				sqOvf_r <= 1'b1;
				if (dropCnt_r != 8'hff) begin
					dropCnt_r <= 8'(dropCnt_r + 1'b1);
				end
			end else begin
				if (lenHiRead && dropped_r) begin
					dropped_r <= 1'b0;
					dropCnt_r <= 8'h00;
				end
				if (fshRead) begin
					sqOvf_r <= 1'b0;
				end
			end
			if (rxQueueWrite && rxQueueFull) begin
				rxOvf_r <= 1'b1;
			end else if (fshRead) begin
				rxOvf_r <= 1'b0;
			end
		end
	end

	assign statusQueueIrq = (sqCnt_r >= (PW+1)'(cfg1_r[C1_LEVEL] ? LEVEL_HIGH : LEVEL_LOW));

	// receive length count and overrun discard
	assign rxOverStep = rxByteValid && !rxStartFlag && (rxCnt_r >= rxMaxLen);
	assign rxQueueWrite = rxByteValid && !discard_r && !rxOverStep;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rxCnt_r <= LEN_ZERO;
			discard_r <= 1'b0;
			overSeen_r <= 1'b0;
		end else begin
			if (rxStartFlag) begin
				rxCnt_r <= LEN_ZERO;
				discard_r <= 1'b0;
				overSeen_r <= 1'b0;
			end else if (rxOverStep) begin
				discard_r <= 1'b1;
				overSeen_r <= 1'b1;
			end else if (rxByteValid && !discard_r) begin
				rxCnt_r <= 13'(rxCnt_r + 1'b1);
			end
		end
	end

	// transmit frame cutting
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			txCnt_r <= LEN_ZERO;
			txFrameEnd <= 1'b0;
		end else begin
			txFrameEnd <= 1'b0;
			if (!cfg1_r[C1_SPLIT] || txFrameLen == LEN_ZERO) begin
				txCnt_r <= LEN_ZERO;
			end else if (txByteValid) begin
				if (13'(txCnt_r + 1'b1) == txFrameLen) begin
					txCnt_r <= LEN_ZERO;
					txFrameEnd <= 1'b1;
				end else begin
					txCnt_r <= 13'(txCnt_r + 1'b1);
				end
			end
		end
	end

	// ask carrier and demodulation by edge age
	assign rawRx = cfg1_r[C1_ALTRX] ? irReceivePin : serialInPin;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			carCnt_r <= '0;
			carrier_r <= 1'b0;
			edgeAge_r <= CW'(ASK_HALF * 2);
			inPrev_r <= 1'b0;
		end else begin
			if (carCnt_r == CW'(ASK_HALF - 1)) begin
				carCnt_r <= '0;
				carrier_r <= !carrier_r;
			end else begin
				carCnt_r <= CW'(carCnt_r + 1'b1);
			end
			inPrev_r <= rawRx;
			if (rawRx != inPrev_r) begin
				edgeAge_r <= '0;
			end else if (edgeAge_r != CW'(ASK_HALF * 2)) begin
				edgeAge_r <= CW'(edgeAge_r + 1'b1);
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			serialOutPin <= 1'b0;
			irRxData <= 1'b0;
		end else begin
			serialOutPin <= cfg2_r[C2_MODBYP] ? txSerial : (txSerial & carrier_r);
			irRxData <= cfg2_r[C2_DEMBYP] ? rawRx : (edgeAge_r < CW'(ASK_HALF * 2));
		end
	end

	assign handshakeStatus = cfg1_r[C1_HSMASK] ? HSR_MASKED : uartHandshake;
	assign flowSettings = flow_r[0] ? flow_r : 8'h00;
	assign duplexFull = cfg1_r[C1_DUPLEX];
	assign fastCheckWidth = cfg2_r[C2_FASTW];
	assign midCheckWidth = cfg2_r[C2_MIDW];
	assign checkInvert = cfg2_r[C2_INV];
	assign checkOmit = cfg2_r[C2_OMIT];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_flow_gated: assert property (!flow_r[0] |-> flowSettings == 8'h00)
		else $error("flow settings active while disabled");
	a_ssr_read: assert property (rdAcc && idx == IDX_SSR && inSet5 |=> hrdata[7:0] == 8'hec)
		else $error("selector readback wrong");
	a_irq_level: assert property (statusQueueIrq == (cfg1_r[6] ? sqCnt_r >= 4 : sqCnt_r >= 2))
		else $error("queue irq level wrong");
	a_alt_pin: assert property (cfg1_r[4] && cfg2_r[6] |=> irRxData == $past(irReceivePin))
		else $error("alternate pin not used");
	a_hs_mask: assert property (cfg1_r[1] |-> handshakeStatus == 8'h30)
		else $error("handshake mask wrong");
	a_valid_pop: assert property (pop && !push |=> sqCnt_r == $past(sqCnt_r) - 1)
		else $error("pop did not remove entry");
	a_drop_set: assert property (frameDone && sqFull && !pop |=> dropped_r && sqOvf_r)
		else $error("lost frame not flagged");
	a_drop_read: assert property (rdAcc && inSet5 && idx == IDX_LENHI && dropped_r |=> hrdata == 0)
		else $error("dropped high read not zero");
	a_rx_discard: assert property (rxOverStep ##1 !rxStartFlag[*2] |-> !rxQueueWrite)
		else $error("write after overrun");
	a_rx_ovf: assert property (rxQueueWrite && rxQueueFull |=> rxOvf_r)
		else $error("rx overflow not flagged");
	a_carrier: assert property ($rose(carrier_r) |=> !$rose(carrier_r)[*5])
		else $error("carrier too fast");
	a_tx_split: assert property (txFrameEnd |-> cfg1_r[5] && $past(txCnt_r) == 13'(txFrameLen - 1'b1))
		else $error("split at wrong length");

	c_push_pop: cover property (push ##[1:20] pop);
	c_dropped: cover property (frameDone && !push);
	c_overrun: cover property (rxOverStep ##[1:50] rxStartFlag);
	c_split: cover property (txFrameEnd);
endmodule : irf_regs

// ### irf_xcvr_model.sv
// Purpose: receive-side transceiver model that sends frames into the register block
// Assumes: the bench calls send at a rising edge
// Notes: error levels show only in the frame-done cycle
`timescale 1ns/1ps
module irf_xcvr_model (
	input wire logic clk,
	output logic rxStartFlag,
	output logic rxByteValid,
	output logic frameDone,
	output logic framePhyErr,
	output logic frameCrcErr
);
	initial begin
		rxStartFlag = 1'b0;
		rxByteValid = 1'b0;
		frameDone = 1'b0;
		framePhyErr = 1'b0;
		frameCrcErr = 1'b0;
	end

	task automatic send(input int nBytes, input logic phy, input logic crc);
		rxStartFlag <= 1'b1;
		@(posedge clk);
		rxStartFlag <= 1'b0;
		repeat (nBytes) begin
			rxByteValid <= 1'b1;
			@(posedge clk);
			rxByteValid <= 1'b0;
			@(posedge clk);
		end
		framePhyErr <= phy;
		frameCrcErr <= crc;
		frameDone <= 1'b1;
		@(posedge clk);
		frameDone <= 1'b0;
		// outside the done cycle the error lines are not held
		framePhyErr <= ~phy;
		frameCrcErr <= ~crc;
	endtask : send
endmodule : irf_xcvr_model

// ### tb.sv
// Purpose: self-checking bench for the infrared status and config registers
// Assumes: zero-wait AHB-Lite slave, one register per word
// Notes: each scenario is one task
`timescale 1ns/1ps
module tb;
	import irf_pkg::*;
	logic clk, arst_n, hsel, hwrite, hreadyout, hresp, txSerial, rxQueueFull;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [12:0] rxMaxLen;
	logic rxStartFlag, rxByteValid, frameDone, framePhyErr, frameCrcErr;
	logic serialOutPin, statusQueueIrq, duplexFull, fastCheckWidth, midCheckWidth;
	logic checkInvert, checkOmit;
	logic [7:0] handshakeStatus, flowSettings;
	logic serialInPin, irReceivePin, irRxData, rxQueueWrite, txFrameEnd, txByteValid;
	logic [12:0] txFrameLen;
	int nWrite = 0;
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;

	irf_regs u_irf_regs (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .uartHandshake(8'h5a),
		.serialInPin(serialInPin), .irReceivePin(irReceivePin), .txSerial(txSerial),
		.rxByteValid(rxByteValid), .rxStartFlag(rxStartFlag), .rxQueueFull(rxQueueFull),
		.frameDone(frameDone), .framePhyErr(framePhyErr), .frameCrcErr(frameCrcErr),
		.rxMaxLen(rxMaxLen), .txByteValid(txByteValid), .txFrameLen(txFrameLen),
		.serialOutPin(serialOutPin), .irRxData(irRxData), .rxQueueWrite(rxQueueWrite),
		.txFrameEnd(txFrameEnd),
		.statusQueueIrq(statusQueueIrq), .handshakeStatus(handshakeStatus),
		.flowSettings(flowSettings), .duplexFull(duplexFull), .fastCheckWidth(fastCheckWidth),
		.midCheckWidth(midCheckWidth), .checkInvert(checkInvert), .checkOmit(checkOmit));
	irf_xcvr_model u_irf_xcvr_model (.clk(clk), .rxStartFlag(rxStartFlag),
		.rxByteValid(rxByteValid), .frameDone(frameDone), .framePhyErr(framePhyErr),
		.frameCrcErr(frameCrcErr));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rxQueueWrite === 1'b1) begin
			nWrite <= nWrite + 1;
		end
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] wd,
		output logic [7:0] rd);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {27'h0, a};
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h0, wd};
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata[7:0];
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] v;
		bus(1'b1, a, d, v);
		@(posedge clk);
	endtask : wr

	task automatic rdchk(input string nm, input logic [4:0] a, input logic [7:0] exp);
		logic [7:0] v;
		bus(1'b0, a, 8'h00, v);
		chk(nm, exp, v);
	endtask : rdchk

	task automatic t_reset;
		rdchk("selector", 5'h0c, SET5_CODE);
		rdchk("cfg1", 5'h10, RST_CFG1);
		chk("fastWidth", 8'h01, {7'h0, fastCheckWidth});
		chk("handshake", 8'h5a, handshakeStatus);
		chk("hresp", 8'h00, {7'h0, hresp});
	endtask : t_reset

	task automatic t_flow;
		wr(5'h08, 8'hee);
		chk("flowOff", 8'h00, flowSettings);
		wr(5'h08, 8'hef);
		chk("flowOn", 8'hef, flowSettings);
	endtask : t_flow

	task automatic t_cfg1;
		wr(5'h10, 8'h53);
		chk("hsMasked", HSR_MASKED, handshakeStatus);
		chk("duplex", 8'h01, {7'h0, duplexFull});
		rdchk("cfg1", 5'h10, 8'h53);
		wr(5'h10, 8'h00);
		chk("halfDuplex", 8'h00, {7'h0, duplexFull});
		chk("hsNormal", 8'h5a, handshakeStatus);
	endtask : t_cfg1

	task automatic t_frames;
		int base;
		u_irf_xcvr_model.send(5, 1'b0, 1'b1);
		u_irf_xcvr_model.send(3, 1'b1, 1'b0);
		repeat (2) @(posedge clk);
		chk("irqAt2", 8'h01, {7'h0, statusQueueIrq});
		rdchk("head1", 5'h14, 8'h84);
		rdchk("len1", 5'h18, 8'h05);
		rdchk("lenHi1", 5'h1c, 8'h00);
		chk("irqBelow", 8'h00, {7'h0, statusQueueIrq});
		rdchk("head2", 5'h14, 8'h88);
		rdchk("len2", 5'h18, 8'h03);
		rdchk("lenHi2", 5'h1c, 8'h00);
		rdchk("empty", 5'h14, 8'h00);
		rxMaxLen <= 13'h0003;
		base = nWrite;
		u_irf_xcvr_model.send(5, 1'b0, 1'b0);
		chk("rxWrites", 8'h03, 8'(nWrite - base));
		rdchk("overrun", 5'h14, 8'h90);
		rdchk("lenHi3", 5'h1c, 8'h00);
		// threshold 4, then fill all eight entries and lose a ninth frame
		wr(5'h10, 8'h40);
		rxQueueFull <= 1'b1;
		u_irf_xcvr_model.send(1, 1'b0, 1'b0);
		rxQueueFull <= 1'b0;
		repeat (2) u_irf_xcvr_model.send(0, 1'b0, 1'b0);
		@(posedge clk);
		chk("irqBelow4", 8'h00, {7'h0, statusQueueIrq});
		u_irf_xcvr_model.send(0, 1'b0, 1'b0);
		@(posedge clk);
		chk("irqAt4", 8'h01, {7'h0, statusQueueIrq});
		repeat (5) u_irf_xcvr_model.send(0, 1'b0, 1'b0);
		rdchk("lost", 5'h14, 8'hc3);
		rdchk("lostCount", 5'h18, 8'h01);
		rdchk("lostHi", 5'h1c, 8'h00);
		rdchk("afterLost", 5'h14, 8'h80);
	endtask : t_frames

	task automatic tx_burst(input string nm, input logic [7:0] exp);
		logic [7:0] nEnd;
		nEnd = 8'h00;
		txByteValid <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			txByteValid <= (i < 7) ? 1'b1 : 1'b0;
			if (txFrameEnd === 1'b1) begin
				nEnd = 8'(nEnd + 1'b1);
			end
		end
		chk(nm, exp, nEnd);
	endtask : tx_burst

	task automatic t_split;
		wr(5'h10, 8'h20);
		tx_burst("splitEnds", 8'h02);
		wr(5'h10, 8'h00);
		tx_burst("noSplitEnds", 8'h00);
	endtask : t_split

	task automatic t_set6;
		wr(5'h0c, SET6_CODE);
		rdchk("cfg2", 5'h00, RST_CFG2);
		rdchk("unmapped", 5'h04, 8'h00);
		wr(5'h00, 8'h96);
		chk("invert", 8'h01, {7'h0, checkInvert});
		chk("omit", 8'h01, {7'h0, checkOmit});
		chk("widths", 8'h01, {6'h0, fastCheckWidth, midCheckWidth});
		txSerial <= 1'b1;
		repeat (3) @(posedge clk);
		chk("bypassOut", 8'h01, {7'h0, serialOutPin});
		wr(5'h0c, SET5_CODE);
		rdchk("backTo5", 5'h0c, SET5_CODE);
	endtask : t_set6

	task automatic t_ask;
		logic [7:0] nHigh;
		nHigh = 8'h00;
		wr(5'h0c, SET6_CODE);
		wr(5'h00, 8'h00);
		repeat (ASK_HALF * 2) begin
			@(posedge clk);
			if (serialOutPin === 1'b1) begin
				nHigh = 8'(nHigh + 1'b1);
			end
		end
		chk("askOnCount", 8'(ASK_HALF), nHigh);
		serialInPin <= 1'b1;
		repeat (3) @(posedge clk);
		chk("demodEdge", 8'h01, {7'h0, irRxData});
		repeat (ASK_HALF * 2 + 10) @(posedge clk);
		chk("demodIdle", 8'h00, {7'h0, irRxData});
		wr(5'h00, 8'h40);
		wr(5'h0c, SET5_CODE);
		wr(5'h10, 8'h10);
		irReceivePin <= 1'b1;
		serialInPin <= 1'b0;
		repeat (3) @(posedge clk);
		chk("altPin", 8'h01, {7'h0, irRxData});
		wr(5'h10, 8'h00);
		repeat (2) @(posedge clk);
		chk("mainPin", 8'h00, {7'h0, irRxData});
	endtask : t_ask

	initial begin
		arst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		txSerial = 1'b0;
		rxQueueFull = 1'b0;
		rxMaxLen = 13'h0100;
		serialInPin = 1'b0;
		irReceivePin = 1'b0;
		txByteValid = 1'b0;
		txFrameLen = 13'h0004;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_flow();
		t_cfg1();
		t_frames();
		t_split();
		t_set6();
		t_ask();
		report_and_stop();
	end
endmodule : tb
